/* File: src/compare_deadtime_output_unit.sv */
// Output compare unit with match flags, buffered compare values and dead-time pairs.
// Assumes an external counter that supplies the count, the update point and count-write strobes.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps

module compare_deadtime_output_unit
    import cdo_pkg::*;
(
    // Clock and reset
    input  wire logic                        clock_in,
    input  wire logic                        rst_in,
    // APB slave
    input  wire logic                        psel_in,
    input  wire logic                        penable_in,
    input  wire logic                        pwrite_in,
    input  wire logic [cdo_pkg::ADDR_W-1:0]  paddr_in,
    input  wire logic [cdo_pkg::DATA_W-1:0]  pwdata_in,
    output logic      [cdo_pkg::DATA_W-1:0]  prdata_out,
    output logic                             pready_out,
    output logic                             pslverr_out,
    // Counter side
    input  wire logic [cdo_pkg::COUNT_W-1:0] timer_count_in,
    input  wire logic                        count_written_in,
    input  wire logic                        update_point_in,
    output logic      [cdo_pkg::NUM_CMP-1:0] compare_match_out,
    // Flag service
    input  wire logic [2:0]                  flag_ack_in,
    output logic      [2:0]                  match_request_out,
    // Port pins
    input  wire logic [5:0]                  port_data_in,
    input  wire logic [5:0]                  port_dir_in,
    output cdo_pkg::pin_drive_t              pins_out
);

    import cdo_pkg::*;

    // ****************************************************************
    // Bus decode
    // ****************************************************************

    logic                     setup_rd;
    logic                     acc_wr;
    logic                     mapped;
    logic [DATA_W-1:0]        rd_mux;
    logic [DATA_W-1:0]        rdata_ff;
    logic                     err_ff;

    logic [COUNT_W-1:0]       written_ff [NUM_CMP];
    logic [COUNT_W-1:0]       active_ff  [NUM_CMP];
    ctrl_t                    ctrl_ff;
    logic [7:0]               dead_time_values_ff;
    logic [2:0]               match_flag_ff;
    logic [2:0]               flag_enable_ff;
    logic                     block_ff;
    logic [2:0]               prescale_ff;
    logic [NUM_CMP-1:0]       match_vec;
    logic [NUM_CMP-1:0]       cmp_wr;
    logic [NUM_CMP-1:0]       buffered;
    logic [2:0]               force_vec;
    logic [2:0]               wave_ff;
    logic [2:0]               true_vec;
    logic [2:0]               comp_vec;
    logic [2:0]               dt_mask;
    logic                     dt_tick;

    assign setup_rd = psel_in && !penable_in && !pwrite_in;
    assign acc_wr   = psel_in && penable_in && pwrite_in;

    always_comb begin
        mapped = 1'b1;
        rd_mux = '0;
        case (paddr_in)
            OFS_COMPARE_A:   rd_mux[COUNT_W-1:0] = written_ff[0];
            OFS_COMPARE_B:   rd_mux[COUNT_W-1:0] = written_ff[1];
            OFS_COMPARE_C:   rd_mux[COUNT_W-1:0] = written_ff[2];
            OFS_COMPARE_D:   rd_mux[COUNT_W-1:0] = written_ff[3];
            OFS_CONTROL: begin
                rd_mux[CTL_PWM_LSB +: 3]  = ctrl_ff.pwm_en;
                rd_mux[CTL_INV_BIT]       = ctrl_ff.invert;
                rd_mux[CTL_MODE_LSB +: 6] = ctrl_ff.out_mode;
                rd_mux[CTL_DTPS_LSB +: 2] = ctrl_ff.dt_prescale;
            end
            OFS_FORCE:       rd_mux = '0;
            OFS_FLAGS:       rd_mux[2:0] = match_flag_ff;
            OFS_FLAG_ENABLE: rd_mux[2:0] = flag_enable_ff;
            OFS_DEAD_TIME:   rd_mux[7:0] = dead_time_values_ff;
            default:         mapped = 1'b0;
        endcase
    end

    // Read data is captured in the setup phase so that it leaves a flop in the access phase.
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rdata_ff <= '0;
            err_ff   <= 1'b0;
        end else if (psel_in && !penable_in) begin
            rdata_ff <= setup_rd ? rd_mux : '0;
            err_ff   <= !mapped;
        end
    end

    assign pready_out  = 1'b1;
    assign prdata_out  = rdata_ff;
    assign pslverr_out = psel_in && penable_in && err_ff;

    // ****************************************************************
    // Control registers
    // ****************************************************************

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ctrl_ff <= RST_CTRL;
        end else if (acc_wr && paddr_in == OFS_CONTROL) begin
            ctrl_ff.pwm_en      <= pwdata_in[CTL_PWM_LSB +: 3];
            ctrl_ff.invert      <= pwdata_in[CTL_INV_BIT];
            ctrl_ff.out_mode    <= pwdata_in[CTL_MODE_LSB +: 6];
            ctrl_ff.dt_prescale <= pwdata_in[CTL_DTPS_LSB +: 2];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            dead_time_values_ff <= RST_DEAD_TIME;
        end else if (acc_wr && paddr_in == OFS_DEAD_TIME) begin
            dead_time_values_ff <= pwdata_in[7:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            flag_enable_ff <= 3'h0;
        end else if (acc_wr && paddr_in == OFS_FLAG_ENABLE) begin
            flag_enable_ff <= pwdata_in[2:0];
        end
    end

    assign force_vec = (acc_wr && paddr_in == OFS_FORCE) ? pwdata_in[2:0] : 3'h0;

    // ****************************************************************
    // Compare values and comparators
    // ****************************************************************

    assign cmp_wr[0] = acc_wr && paddr_in == OFS_COMPARE_A;
    assign cmp_wr[1] = acc_wr && paddr_in == OFS_COMPARE_B;
    assign cmp_wr[2] = acc_wr && paddr_in == OFS_COMPARE_C;
    assign cmp_wr[3] = acc_wr && paddr_in == OFS_COMPARE_D;

    // The top value is shared by all channels, so it is buffered whenever any channel runs PWM.
    assign buffered = {ctrl_ff.pwm_en[2], |ctrl_ff.pwm_en, ctrl_ff.pwm_en[1:0]};

    generate
        for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
            localparam logic [COUNT_W-1:0] RST_VAL = (i == 2) ? RST_COMPARE_TOP : RST_COMPARE;

            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    written_ff[i] <= RST_VAL;
                end else if (cmp_wr[i]) begin
                    written_ff[i] <= pwdata_in[COUNT_W-1:0];
                end
            end

            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    active_ff[i] <= RST_VAL;
                end else if (!buffered[i] && cmp_wr[i]) begin
                    active_ff[i] <= pwdata_in[COUNT_W-1:0];
                end else if (buffered[i] && update_point_in) begin
                    active_ff[i] <= written_ff[i];
                end
            end

            assign match_vec[i] = (timer_count_in == active_ff[i]) && !block_ff;
        end
    endgenerate

    // A count write is seen in the cycle it happens, so the block covers the cycle after it.
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            block_ff <= 1'b0;
        end else begin
            block_ff <= count_written_in;
        end
    end

    assign compare_match_out = match_vec;

    // ****************************************************************
    // Match flags
    // ****************************************************************

    generate
        for (genvar k = 0; k < NUM_PAIR; k++) begin : g_flag
            localparam int CH = (k == 2) ? 3 : k;
            logic clr;

            assign clr = (acc_wr && paddr_in == OFS_FLAGS && pwdata_in[k]) || flag_ack_in[k];

            // A match in the clearing cycle wins, so no event is lost.
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    match_flag_ff[k] <= 1'b0;
                end else if (match_vec[CH]) begin
                    match_flag_ff[k] <= 1'b1;
                end else if (clr) begin
                    match_flag_ff[k] <= 1'b0;
                end
            end
        end
    endgenerate

    assign match_request_out = match_flag_ff & flag_enable_ff;

    // ****************************************************************
    // Waveform generator
    // ****************************************************************

    generate
        for (genvar k = 0; k < NUM_PAIR; k++) begin : g_wave
            localparam int CH = (k == 2) ? 3 : k;
            logic [1:0] mode;
            logic       pwm;

            assign mode = ctrl_ff.out_mode[2*k +: 2];
            assign pwm  = ctrl_ff.pwm_en[k];

            // The state is never touched by a mode change, only by matches and strobes.
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    wave_ff[k] <= 1'b0;
                end else if (mode == MODE_NONE) begin
                    wave_ff[k] <= wave_ff[k];
                end else if (pwm) begin
                    if (match_vec[CH]) begin
                        wave_ff[k] <= (mode == MODE_SET);
                    end else if (update_point_in) begin
                        wave_ff[k] <= (mode != MODE_SET);
                    end
                end else if (match_vec[CH] || force_vec[k]) begin
                    case (mode)
                        MODE_TOGGLE: wave_ff[k] <= !wave_ff[k];
                        MODE_CLEAR:  wave_ff[k] <= 1'b0;
                        MODE_SET:    wave_ff[k] <= 1'b1;
                        default:     wave_ff[k] <= wave_ff[k];
                    endcase
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Dead-time prescaler and pairs
    // ****************************************************************

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            prescale_ff <= RST_PRESCALE;
        end else begin
            prescale_ff <= prescale_ff + 3'h1;
        end
    end

    always_comb begin
        case (ctrl_ff.dt_prescale)
            2'h0:    dt_mask = 3'h0;
            2'h1:    dt_mask = 3'h1;
            2'h2:    dt_mask = 3'h3;
            default: dt_mask = 3'h7;
        endcase
    end

    assign dt_tick = ((prescale_ff & dt_mask) == dt_mask);

    generate
        for (genvar k = 0; k < NUM_PAIR; k++) begin : g_dt
            dead_time_pair u_pair (
                .clock_in      (clock_in),
                .rst_in        (rst_in),
                .wave_in       (wave_ff[k]),
                .complement_in (ctrl_ff.pwm_en[k] && ctrl_ff.out_mode[2*k +: 2] == MODE_TOGGLE),
                .invert_in     (ctrl_ff.invert),
                .tick_in       (dt_tick),
                .rise_dt_in    (dead_time_values_ff[DT_RISE_LSB +: DT_W]),
                .fall_dt_in    (dead_time_values_ff[DT_FALL_LSB +: DT_W]),
                .true_out      (true_vec[k]),
                .comp_out      (comp_vec[k])
            );

            // Direction always stays with the port; only the level is taken over.
            assign pins_out.level[2*k]   = (ctrl_ff.out_mode[2*k +: 2] != MODE_NONE) ? true_vec[k]
                                                                                  : port_data_in[2*k];
            assign pins_out.level[2*k+1] = (ctrl_ff.out_mode[2*k +: 2] != MODE_NONE) ? comp_vec[k]
                                                                                  : port_data_in[2*k+1];
            assign pins_out.oe[2*k +: 2] = port_dir_in[2*k +: 2];
        end
    endgenerate

    // ****************************************************************
    // Checks
    // ****************************************************************

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    sequence s_force_a;
        acc_wr && paddr_in == OFS_FORCE && pwdata_in[0] && !ctrl_ff.pwm_en[0];
    endsequence

    sequence s_quiet_a;
        !match_vec[0] && !match_flag_ff[0];
    endsequence

    a_match_equal: assert property (timer_count_in == active_ff[1] && !block_ff |-> match_vec[1])
        else $error("Equal count gave no match.");
    a_flag_delay: assert property (match_vec[0] |=> match_flag_ff[0])
        else $error("Match flag not set one cycle after match.");
    a_ack_clears: assert property (flag_ack_in[1] && !match_vec[1] |=> !match_flag_ff[1])
        else $error("Serviced flag was not cleared.");
    a_normal_direct: assert property (cmp_wr[0] && !ctrl_ff.pwm_en[0]
                                      |=> active_ff[0] == $past(pwdata_in[COUNT_W-1:0]))
        else $error("Normal mode compare write did not take effect directly.");
    a_buffer_waits: assert property (cmp_wr[1] && ctrl_ff.pwm_en[1] && !update_point_in
                                     |=> active_ff[1] == $past(active_ff[1]))
        else $error("Buffered compare value changed before the update point.");
    a_read_pending: assert property (setup_rd && paddr_in == OFS_COMPARE_B
                                     |=> prdata_out[COUNT_W-1:0] == $past(written_ff[1]))
        else $error("Compare read did not return the pending value.");
    a_force_noflag: assert property (s_force_a ##0 s_quiet_a |=> !match_flag_ff[0])
        else $error("Force strobe set a match flag.");
    a_write_blocks: assert property (count_written_in |=> match_vec == '0)
        else $error("Match seen in the cycle after a count write.");
    a_mode_none: assert property (ctrl_ff.out_mode[1:0] == MODE_NONE |=> $stable(wave_ff[0]))
        else $error("Waveform changed with output mode 00.");
    a_force_acts: assert property (s_force_a ##0 ctrl_ff.out_mode[1:0] == MODE_SET |=> wave_ff[0])
        else $error("Force strobe did not set the waveform.");
    a_mode_keep: assert property (acc_wr && paddr_in == OFS_CONTROL
                                  && !match_vec[0] && !update_point_in |=> $stable(wave_ff[0]))
        else $error("Waveform changed on a control write.");
    a_pin_override: assert property (ctrl_ff.out_mode[1:0] != MODE_NONE
                                     |-> pins_out.level[1:0] == {comp_vec[0], true_vec[0]})
        else $error("Pin level not taken over by the pair.");

endmodule

/* File: pkg/cdo_pkg.sv */
// Constants, field layouts and carrier types of the compare and dead-time output unit.
// Assumes a 40 MHz timer clock and an APB master with 32-bit data.
package cdo_pkg;

    localparam int CLOCK_HZ        = 40_000_000;
    localparam int COUNT_W         = 10;
    localparam int ADDR_W          = 12;
    localparam int DATA_W          = 32;
    localparam int NUM_CMP         = 4;
    localparam int NUM_PAIR        = 3;
    localparam int DT_W            = 4;

    // Register byte offsets.
    localparam logic [11:0] OFS_COMPARE_A   = 12'h000;
    localparam logic [11:0] OFS_COMPARE_B   = 12'h004;
    localparam logic [11:0] OFS_COMPARE_C   = 12'h008;
    localparam logic [11:0] OFS_COMPARE_D   = 12'h00c;
    localparam logic [11:0] OFS_CONTROL     = 12'h010;
    localparam logic [11:0] OFS_FORCE       = 12'h014;
    localparam logic [11:0] OFS_FLAGS       = 12'h018;
    localparam logic [11:0] OFS_FLAG_ENABLE = 12'h01c;
    localparam logic [11:0] OFS_DEAD_TIME   = 12'h020;

    // Control word and dead-time register field positions.
    localparam int CTL_PWM_LSB     = 0;
    localparam int CTL_INV_BIT     = 3;
    localparam int CTL_MODE_LSB    = 8;
    localparam int CTL_DTPS_LSB    = 16;
    localparam int DT_RISE_LSB     = 4;
    localparam int DT_FALL_LSB     = 0;

    // Values after reset.
    localparam logic [9:0]  RST_COMPARE     = 10'h000;
    localparam logic [9:0]  RST_COMPARE_TOP = 10'h0ff;
    localparam logic [7:0]  RST_DEAD_TIME   = 8'h00;
    localparam logic [2:0]  RST_PRESCALE    = 3'h0;

    // Output mode encodings.
    localparam logic [1:0]  MODE_NONE       = 2'h0;
    localparam logic [1:0]  MODE_TOGGLE     = 2'h1;
    localparam logic [1:0]  MODE_CLEAR      = 2'h2;
    localparam logic [1:0]  MODE_SET        = 2'h3;

    typedef struct packed {
        logic [1:0] dt_prescale;
        logic [5:0] out_mode;
        logic       invert;
        logic [2:0] pwm_en;
    } ctrl_t;

    localparam ctrl_t RST_CTRL = '{dt_prescale: 2'h0, out_mode: 6'h00, invert: 1'b0, pwm_en: 3'h0};

    typedef struct packed {
        logic [5:0] level;
        logic [5:0] oe;
    } pin_drive_t;

endpackage

/* File: src/dead_time_pair.sv */
// One dead-time generator turning a waveform into a true and complement pair.
// Assumes a prescaled tick from the parent on the same clock, one cycle wide except at prescale setting 0, where it stays high.
`timescale 1ns/1ps

module dead_time_pair
    import cdo_pkg::*;
(
    // Clock and reset
    input  wire logic            clock_in,
    input  wire logic            rst_in,
    // Waveform and settings
    input  wire logic            wave_in,
    input  wire logic            complement_in,
    input  wire logic            invert_in,
    input  wire logic            tick_in,
    input  wire logic [DT_W-1:0] rise_dt_in,
    input  wire logic [DT_W-1:0] fall_dt_in,
    // Pair outputs
    output logic                 true_out,
    output logic                 comp_out
);

    logic            prev_ff;
    logic [DT_W-1:0] cnt_ff;
    logic [DT_W-1:0] nxt_cnt;
    logic            true_ff;
    logic            comp_ff;
    logic            idle;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (wave_in != prev_ff) begin
            nxt_cnt = wave_in ? rise_dt_in : fall_dt_in;
        end else if (cnt_ff != '0 && tick_in) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
        idle = (nxt_cnt == '0);
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            prev_ff <= 1'b0;
            cnt_ff  <= '0;
        end else begin
            prev_ff <= wave_in;
            cnt_ff  <= nxt_cnt;
        end
    end

    // Outputs always come from flops, so even zero dead time costs one cycle of lag.
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            true_ff <= 1'b0;
            comp_ff <= 1'b0;
        end else if (complement_in) begin
            true_ff <= (wave_in & idle) ^ invert_in;
            comp_ff <= (~wave_in & idle) ^ invert_in;
        end else begin
            true_ff <= wave_in;
            comp_ff <= 1'b0;
        end
    end

    assign true_out = true_ff;
    assign comp_out = comp_ff;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    a_plain_delay: assert property (!complement_in |=> true_ff == $past(wave_in))
        else $error("Plain path does not delay the waveform by one cycle.");
    a_pair_overlap: assert property (complement_in && !invert_in |=> !(true_ff && comp_ff))
        else $error("Complementary outputs overlap.");
    a_zero_dead: assert property (complement_in && !invert_in && rise_dt_in == '0 && $rose(wave_in)
                                  |=> true_ff)
        else $error("Zero dead time does not give exactly one cycle of lag.");

endmodule

/* File: sim/power_switch_model.sv */
// Model of the power switches hanging on the output pin pairs.
// Assumes even pins carry the true output and odd pins the complement.
`timescale 1ns/1ps
module power_switch_model
    import cdo_pkg::*;
(
    // Clock, reset and pins
    input  wire logic                clock_in,
    input  wire logic                rst_in,
    input  wire cdo_pkg::pin_drive_t pins_in,
    // Sticky shoot-through report
    output logic                     overlap_out
);
    // Both switches of one leg on together would short the supply rail.
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            overlap_out <= 1'b0;
        end else begin
            for (int k = 0; k < NUM_PAIR; k++) begin
                if (&{pins_in.oe[2*k+:2], pins_in.level[2*k+:2]}) begin
                    overlap_out <= 1'b1;
                end
            end
        end
    end
endmodule

/* File: sim/compare_deadtime_output_unit_tb_top.sv */
// Self-checking bench for the compare and dead-time output unit.
// Assumes a zero-wait APB slave and the switch model on the pins.
`timescale 1ns/1ps
module compare_deadtime_output_unit_tb_top
    import cdo_pkg::*;
;
    // ****************************
    // Signals, drivers and checks
    // ****************************
    logic        clock_in = 1'b0;
    logic        rst_in   = 1'b1;
    logic        psel     = 1'b0;
    logic        pen      = 1'b0;
    logic        pwr      = 1'b0;
    logic [11:0] padr     = 12'h000;
    logic [31:0] pwd      = 32'h0;
    logic [9:0]  cnt      = 10'h3ff;
    logic        cw       = 1'b0;
    logic        upd      = 1'b0;
    logic [2:0]  ack      = 3'h0;
    logic [5:0]  pdat     = 6'h04;
    logic [5:0]  pdir     = 6'h3f;
    logic [31:0] prd;
    logic        prdy;
    logic        perr;
    logic [3:0]  mt;
    logic [2:0]  rq;
    pin_drive_t  pins;
    logic        ovl;
    logic [31:0] r;
    logic        e;
    int          err_count  = 0;
    int          n_compared = 0;
    compare_deadtime_output_unit uut (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
        .pslverr_out(perr), .timer_count_in(cnt), .count_written_in(cw), .update_point_in(upd),
        .compare_match_out(mt), .flag_ack_in(ack), .match_request_out(rq), .port_data_in(pdat),
        .port_dir_in(pdir), .pins_out(pins));
    power_switch_model sw (.clock_in(clock_in), .rst_in(rst_in), .pins_in(pins), .overlap_out(ovl));
    initial begin
        forever #12.5 clock_in = ~clock_in;
    end
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
            err_count++;
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_in);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clock_in);
        pen <= 1'b1;
        do @(posedge clock_in); while (prdy !== 1'b1);
        r = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task t_match;
        apb(1'b1, OFS_COMPARE_A, 32'h10);
        apb(1'b1, OFS_FLAG_ENABLE, 32'h7);
        apb(1'b1, OFS_FLAGS, 32'h7);
        @(posedge clock_in);
        cnt <= 10'h010;
        cyc(0);
        chk("match", 32'h1, mt);
        @(posedge clock_in);
        cnt <= 10'h3ff;
        cyc(0);
        chk("flag", 32'h1, rq);
        @(posedge clock_in);
        ack <= 3'h1;
        @(posedge clock_in);
        ack <= 3'h0;
        cyc(0);
        chk("ack", 32'h0, rq);
    endtask
    task t_block;
        @(posedge clock_in);
        cw <= 1'b1;
        @(posedge clock_in);
        cw <= 1'b0;
        cnt <= 10'h010;
        cyc(0);
        chk("blocked", 32'h0, mt[0]);
        @(posedge clock_in);
        cnt <= 10'h3ff;
        cyc(0);
        chk("no flag", 32'h0, rq);
    endtask
    task t_buffer;
        apb(1'b1, OFS_CONTROL, 32'h1);
        apb(1'b1, OFS_COMPARE_A, 32'h20);
        apb(1'b0, OFS_COMPARE_A, 32'h0);
        chk("pending", 32'h20, r);
        @(posedge clock_in);
        cnt <= 10'h020;
        cyc(0);
        chk("held", 32'h0, mt[0]);
        @(posedge clock_in);
        upd <= 1'b1;
        @(posedge clock_in);
        upd <= 1'b0;
        cyc(0);
        chk("updated", 32'h1, mt[0]);
        @(posedge clock_in);
        cnt <= 10'h3ff;
        apb(1'b1, OFS_FLAGS, 32'h7);
    endtask
    task t_force;
        apb(1'b1, OFS_CONTROL, 32'h100);
        apb(1'b1, OFS_FORCE, 32'h1);
        cyc(0);
        chk("lag", 32'h0, pins.level[0]);
        cyc(1);
        chk("forced", 32'h1, pins.level[1:0]);
        chk("no flag", 32'h0, rq);
        chk("port", 32'h1, pins.level[2]);
        chk("dir", 32'h3f, pins.oe);
        apb(1'b1, OFS_CONTROL, 32'h200);
        apb(1'b1, OFS_FORCE, 32'h1);
        cyc(1);
        chk("forced clear", 32'h0, pins.level[0]);
        apb(1'b1, OFS_CONTROL, 32'h300);
        apb(1'b1, OFS_FORCE, 32'h1);
        cyc(1);
        chk("forced set", 32'h1, pins.level[0]);
    endtask
    task t_pair;
        apb(1'b1, OFS_CONTROL, 32'h101);
        cyc(4);
        chk("kept", 32'h1, pins.level[1:0]);
        apb(1'b1, OFS_DEAD_TIME, 32'h03);
        @(posedge clock_in);
        cnt <= 10'h020;
        @(posedge clock_in);
        cnt <= 10'h3ff;
        cyc(2);
        chk("dead", 32'h0, pins.level[1:0]);
        cyc(6);
        chk("comp on", 32'h2, pins.level[1:0]);
        chk("overlap", 32'h0, ovl);
        @(posedge clock_in);
        upd <= 1'b1;
        @(posedge clock_in);
        upd <= 1'b0;
        cyc(0);
        chk("rise wait", 32'h2, pins.level[1:0]);
        cyc(1);
        chk("rise lag", 32'h1, pins.level[1:0]);
        chk("overlap rise", 32'h0, ovl);
        apb(1'b1, OFS_CONTROL, 32'h109);
        cyc(4);
        chk("inverted", 32'h2, pins.level[1:0]);
    endtask
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #50000;
        err_count++;
        finish_test;
    end
    initial begin
        repeat (4) @(posedge clock_in);
        rst_in <= 1'b0;
        cyc(1);
        chk("reset pins", 32'h4, pins.level);
        apb(1'b0, OFS_COMPARE_C, 32'h0);
        chk("top reset", 32'h0ff, r);
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped", 32'h1, e);
        t_match;
        t_block;
        t_buffer;
        t_force;
        t_pair;
        finish_test;
    end
endmodule
